// File: logic/icp_pkg.sv
// Package: object indices, widths, reset values and carrier types
package icp_pkg;
  localparam int IDX_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] IDX_INIT_PITCH = 16'h2200;
  localparam logic [15:0] IDX_INIT_ROLL = 16'h2210;
  localparam logic [15:0] IDX_MOUNT_SEL = 16'h2220;
  localparam logic [15:0] IDX_ROT_YAW = 16'h2230;
  localparam logic [15:0] IDX_ROT_PITCH = 16'h2240;
  localparam logic [15:0] IDX_ROT_ROLL = 16'h2250;
  localparam logic [15:0] IDX_LEVEL_TRIG = 16'h2300;
  localparam logic [15:0] IDX_FAC_PITCH = 16'h2400;
  localparam logic [15:0] IDX_FAC_ROLL = 16'h2410;
  localparam logic [15:0] IDX_GYRO_X = 16'h2420;
  localparam logic [15:0] IDX_GYRO_Y = 16'h2430;
  localparam logic [15:0] IDX_GYRO_Z = 16'h2440;
  localparam logic [15:0] IDX_ACC_X = 16'h2450;
  localparam logic [15:0] IDX_ACC_Y = 16'h2460;
  localparam logic [15:0] IDX_ACC_Z = 16'h2470;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] TRIG_NO = 8'h00;
  localparam logic [7:0] TRIG_YES = 8'h01;
  localparam logic [7:0] MOUNT_HORIZ = 8'h00;
  localparam logic [7:0] MOUNT_VERT = 8'h01;
  localparam int CAL_N = 8;

  // Access outcome reported with each answer
  typedef enum logic [1:0] {ICP_OK, ICP_RO_ERR, ICP_NO_OBJ} icp_resp_e;

  typedef struct packed {
    logic [31:0] yaw;
    logic [31:0] pitch;
    logic [31:0] roll;
  } icp_rot_s;

  typedef struct packed {
    logic [31:0] pitch;
    logic [7:0] roll;
  } icp_inst_s;
endpackage

// File: logic/icp_cal_store.sv
// Read-only factory calibration store, loaded internally
`timescale 1ns/100ps
`default_nettype none
module icp_cal_store
  import icp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [CAL_N*DATA_W-1:0] load_data,
  input wire logic [2:0] rd_sel,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem_q [CAL_N];
  logic [DATA_W-1:0] mem_d [CAL_N];

  genvar g;
  generate
    for (g = 0; g < CAL_N; g++) begin : g_cal
      // Only the internal load port writes; the bus has no path here
      always_comb begin
        mem_d[g] = load ? load_data[g*DATA_W +: DATA_W] : mem_q[g];
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mem_q[g] <= RST_WORD;
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
    end
  endgenerate

  assign rd_data = mem_q[rd_sel];
endmodule // icp_cal_store
`default_nettype wire

// File: logic/icp_bank.sv
// Installation and calibration parameter bank reached by object index
`timescale 1ns/100ps
`default_nettype none
module icp_bank
  import icp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic ACC_VALID,
  input wire logic ACC_WRITE,
  input wire logic [IDX_W-1:0] ACC_INDEX,
  input wire logic [DATA_W-1:0] ACC_WDATA,
  output logic ACC_DONE,
  output logic [DATA_W-1:0] ACC_RDATA,
  output icp_resp_e ACC_RESP,
  input wire logic [DATA_W-1:0] MEAS_PITCH,
  input wire logic [7:0] MEAS_ROLL,
  input wire logic CAL_LOAD,
  input wire logic [CAL_N*DATA_W-1:0] CAL_DATA,
  output icp_rot_s FRAME_ROT,
  output logic MOUNT_VERTICAL,
  output icp_inst_s INSTALL_ANGLES,
  output logic LEVEL_CAPTURED
);
  typedef enum logic [1:0] {ICP_D_NONE, ICP_D_RW, ICP_D_TRIG, ICP_D_CAL}
    icp_kind_e;

  // Object index to kind; used only by the answer path, for reads and writes alike
  function automatic icp_kind_e obj_kind(input logic [15:0] idx);
    case (idx)
      IDX_INIT_PITCH, IDX_INIT_ROLL, IDX_MOUNT_SEL,
      IDX_ROT_YAW, IDX_ROT_PITCH, IDX_ROT_ROLL: obj_kind = ICP_D_RW;
      IDX_LEVEL_TRIG: obj_kind = ICP_D_TRIG;
      IDX_FAC_PITCH, IDX_FAC_ROLL, IDX_GYRO_X, IDX_GYRO_Y, IDX_GYRO_Z,
      IDX_ACC_X, IDX_ACC_Y, IDX_ACC_Z: obj_kind = ICP_D_CAL;
      default: obj_kind = ICP_D_NONE;
    endcase
  endfunction

  // Byte-wide objects live in the low bits of the data word
  localparam int BYTE_W = 8;
  localparam int PAD_W = DATA_W - BYTE_W;
  // Calibration indices step by 0x10, so three index bits pick the word
  localparam int CAL_SEL_LSB = 4;
  localparam int CAL_SEL_W = 3;

  // Byte objects answer zero-extended to a full word
  function automatic logic [DATA_W-1:0] zext_byte(
    input logic [BYTE_W-1:0] b
  );
    zext_byte = {{PAD_W{1'b0}}, b};
  endfunction

  icp_rot_s rot_q, rot_d;
  icp_inst_s inst_q, inst_d;
  logic [BYTE_W-1:0] mount_q, mount_d;
  logic cap_q, cap_d;
  logic done_q, done_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  icp_resp_e resp_q, resp_d;
  icp_kind_e kind;
  logic [CAL_SEL_W-1:0] cal_sel;
  logic [DATA_W-1:0] cal_rd;
  logic wr;
  logic trig_yes;

  assign kind = obj_kind(ACC_INDEX);
  assign wr = ACC_VALID && ACC_WRITE;
  assign cal_sel = ACC_INDEX[CAL_SEL_LSB +: CAL_SEL_W];
  // Only the yes code fires a capture; any other trigger value is dropped
  assign trig_yes = wr && (ACC_INDEX == IDX_LEVEL_TRIG) &&
    (ACC_WDATA[BYTE_W-1:0] == TRIG_YES);

  icp_cal_store u_cal (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .load(CAL_LOAD),
    .load_data(CAL_DATA),
    .rd_sel(cal_sel),
    .rd_data(cal_rd)
  );

  // Rotation angles are stored verbatim with no range clamp, so any angle
  // in the signed range is kept, not only quarter turns
  always_comb begin
    rot_d = rot_q;
    if (wr) begin
      case (ACC_INDEX)
        IDX_ROT_YAW: rot_d.yaw = ACC_WDATA;
        IDX_ROT_PITCH: rot_d.pitch = ACC_WDATA;
        IDX_ROT_ROLL: rot_d.roll = ACC_WDATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rot_q <= '{yaw: RST_WORD, pitch: RST_WORD, roll: RST_WORD};
    end else begin
      rot_q <= rot_d;
    end
  end

  // Installation angles: a manual write and a capture never meet in one
  // cycle, since one access carries one index
  always_comb begin
    inst_d = inst_q;
    cap_d = 1'b0;
    if (trig_yes) begin
      inst_d.pitch = MEAS_PITCH;
      inst_d.roll = MEAS_ROLL;
      cap_d = 1'b1;
    end else if (wr) begin
      case (ACC_INDEX)
        IDX_INIT_PITCH: inst_d.pitch = ACC_WDATA;
        IDX_INIT_ROLL: inst_d.roll = ACC_WDATA[BYTE_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      inst_q <= '{pitch: RST_WORD, roll: RST_BYTE};
      cap_q <= 1'b0;
    end else begin
      inst_q <= inst_d;
      cap_q <= cap_d;
    end
  end

  // Values other than 0 and 1 are kept as written, but only 1 selects
  // vertical mounting; the rest fall back to horizontal
  always_comb begin
    mount_d = mount_q;
    if (wr && (ACC_INDEX == IDX_MOUNT_SEL)) begin
      mount_d = ACC_WDATA[BYTE_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      mount_q <= MOUNT_HORIZ;
    end else begin
      mount_q <= mount_d;
    end
  end

  // Answer path: one cycle after each accepted access
  // A read in the cycle of a write to the same object sees the old value
  always_comb begin
    done_d = ACC_VALID;
    rdata_d = RST_WORD;
    resp_d = ICP_OK;
    case (kind)
      ICP_D_RW: begin
        case (ACC_INDEX)
          IDX_INIT_PITCH: rdata_d = inst_q.pitch;
          IDX_INIT_ROLL: rdata_d = zext_byte(inst_q.roll);
          IDX_MOUNT_SEL: rdata_d = zext_byte(mount_q);
          IDX_ROT_YAW: rdata_d = rot_q.yaw;
          IDX_ROT_PITCH: rdata_d = rot_q.pitch;
          IDX_ROT_ROLL: rdata_d = rot_q.roll;
          default: rdata_d = RST_WORD;
        endcase
      end
      // Trigger is not a setting: reads always give no
      ICP_D_TRIG: rdata_d = zext_byte(TRIG_NO);
      ICP_D_CAL: begin
        if (ACC_WRITE) begin
          resp_d = ICP_RO_ERR;
        end else if (ACC_INDEX == IDX_FAC_ROLL) begin
          rdata_d = zext_byte(cal_rd[BYTE_W-1:0]);
        end else begin
          rdata_d = cal_rd;
        end
      end
      default: resp_d = ICP_NO_OBJ;
    endcase
    // Writes and idle cycles answer zero, so no stale word leaks out
    if (!ACC_VALID || ACC_WRITE) begin
      rdata_d = RST_WORD;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      done_q <= 1'b0;
      rdata_q <= RST_WORD;
      resp_q <= ICP_OK;
    end else begin
      done_q <= done_d;
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end

  // Outputs come straight from flops, except MOUNT_VERTICAL, which is a compare on mount_q
  assign ACC_DONE = done_q;
  assign ACC_RDATA = rdata_q;
  assign ACC_RESP = resp_q;
  assign FRAME_ROT = rot_q;
  assign MOUNT_VERTICAL = (mount_q == MOUNT_VERT);
  assign INSTALL_ANGLES = inst_q;
  // One-cycle pulse per capture; a consumer must sample every cycle
  assign LEVEL_CAPTURED = cap_q;
endmodule // icp_bank
`default_nettype wire

// File: verification/icp_chk.sv
// Port checker for the parameter bank
`timescale 1ns/100ps
`default_nettype none
module icp_chk
  import icp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic ACC_VALID,
  input wire logic ACC_WRITE,
  input wire logic [IDX_W-1:0] ACC_INDEX,
  input wire logic [DATA_W-1:0] ACC_WDATA,
  input wire logic ACC_DONE,
  input wire logic [DATA_W-1:0] ACC_RDATA,
  input wire icp_resp_e ACC_RESP,
  input wire logic [DATA_W-1:0] MEAS_PITCH,
  input wire logic [7:0] MEAS_ROLL,
  input wire icp_rot_s FRAME_ROT,
  input wire logic MOUNT_VERTICAL,
  input wire icp_inst_s INSTALL_ANGLES,
  input wire logic LEVEL_CAPTURED
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic wr;
  logic trig;
  assign wr = ACC_VALID && ACC_WRITE;
  assign trig = wr && ACC_INDEX == IDX_LEVEL_TRIG &&
    ACC_WDATA[7:0] == TRIG_YES;
  done_pulse_a: assert property (ACC_VALID |=> ACC_DONE)
    else $error("no answer");
  capture_load_a: assert property (trig |=> LEVEL_CAPTURED &&
    INSTALL_ANGLES == {$past(MEAS_PITCH), $past(MEAS_ROLL)})
    else $error("capture");
  capture_cause_a: assert property (LEVEL_CAPTURED |-> $past(trig))
    else $error("stray capture");
  trig_reads_no_a: assert property (ACC_VALID && !ACC_WRITE &&
    ACC_INDEX == IDX_LEVEL_TRIG |=> ACC_RDATA == 32'h0000_0000)
    else $error("trig read");
  rot_yaw_a: assert property (wr && ACC_INDEX == IDX_ROT_YAW |=>
    FRAME_ROT.yaw == $past(ACC_WDATA)) else $error("yaw");
  rot_pitch_a: assert property (wr && ACC_INDEX == IDX_ROT_PITCH |=>
    FRAME_ROT.pitch == $past(ACC_WDATA)) else $error("rot pitch");
  rot_roll_a: assert property (wr && ACC_INDEX == IDX_ROT_ROLL |=>
    FRAME_ROT.roll == $past(ACC_WDATA)) else $error("rot roll");
  mount_vert_a: assert property (wr && ACC_INDEX == IDX_MOUNT_SEL |=>
    MOUNT_VERTICAL == ($past(ACC_WDATA[7:0]) == MOUNT_VERT))
    else $error("mount");
  inst_pitch_a: assert property (wr && ACC_INDEX == IDX_INIT_PITCH |=>
    INSTALL_ANGLES.pitch == $past(ACC_WDATA)) else $error("inst pitch");
  cal_refuse_a: assert property (wr && ACC_INDEX[3:0] == 4'h0 &&
    ACC_INDEX inside {[IDX_FAC_PITCH:IDX_ACC_Z]} |=> ACC_RESP == ICP_RO_ERR)
    else $error("cal write taken");
  cover property (trig);
  cover property (MOUNT_VERTICAL);
  cover property (ACC_DONE && ACC_RESP == ICP_RO_ERR);
endmodule // icp_chk
`default_nettype wire

// File: verification/icp_master.sv
// Object access master model, one access at a time
`timescale 1ns/100ps
`default_nettype none
module icp_master
  import icp_pkg::*;
(
  input wire logic clk,
  output logic valid,
  output logic write,
  output logic [15:0] index,
  output logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire icp_resp_e resp
);
  initial {valid, write, index, wdata} = '0;
  task automatic acc(input logic we, input logic [15:0] ix,
    input logic [31:0] wd, output logic [31:0] r, output icp_resp_e s);
    @(posedge clk);
    {valid, write, index, wdata} <= {1'b1, we, ix, wd};
    @(posedge clk);
    // Released lines show junk, so a stale value never passes
    {valid, write, index, wdata} <= {1'b0, ~we, ~ix, ~wd};
    // Answer stands for the cycle after the taken edge; read it at its end
    @(posedge clk);
    r = rdata;
    s = resp;
  endtask
endmodule // icp_master
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the parameter bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import icp_pkg::*;
  logic clk = 0, rst_n = 0, v, w, ld = 0, mv, cap, dn;
  logic [15:0] x;
  logic [31:0] d, rd, mp = 0, sv[6];
  logic [7:0] mr = 0;
  logic [255:0] cal = 0;
  icp_resp_e rs;
  icp_rot_s rot;
  icp_inst_s ins;
  int failures = 0, comparisons = 0, cyc = 0;
  icp_master m (.clk(clk), .valid(v), .write(w), .index(x), .wdata(d),
    .rdata(rd), .resp(rs));
  icp_bank DUT (.REF_CLK(clk), .RST_N(rst_n), .ACC_VALID(v), .ACC_WRITE(w),
    .ACC_INDEX(x), .ACC_WDATA(d), .ACC_DONE(dn), .ACC_RDATA(rd), .ACC_RESP(rs),
    .MEAS_PITCH(mp), .MEAS_ROLL(mr), .CAL_LOAD(ld), .CAL_DATA(cal),
    .FRAME_ROT(rot), .MOUNT_VERTICAL(mv), .INSTALL_ANGLES(ins),
    .LEVEL_CAPTURED(cap));
  initial forever #4 clk = ~clk;
  task complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [95:0] s, input logic [95:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] ix(logic [15:0] b, int k);
    return b + 16'(16 * k);
  endfunction
  task a(logic we, logic [15:0] i, logic [31:0] wd, logic [31:0] e,
    icp_resp_e es);
    logic [31:0] r;
    icp_resp_e s;
    m.acc(we, i, wd, r, s);
    chk(dn, 1'b1);
    chk(r, e);
    chk(s, es);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    logic [31:0] t;
    void'($urandom(11196));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    for (int k = 0; k < 6; k++) a(0, ix(16'h2200, k), 0, 0, ICP_OK);
    a(0, IDX_LEVEL_TRIG, 0, 0, ICP_OK);
    // Rotation is set before the install angles are captured
    for (int it = 0; it < 4; it++) begin
      for (int k = 0; k < 6; k++) begin
        t = $urandom;
        if (k == 2) t = it % 3;
        sv[k] = (k == 1 || k == 2) ? {24'h00_0000, t[7:0]} : t;
        a(1, ix(16'h2200, k), t, 0, ICP_OK);
        a(0, ix(16'h2200, k), 0, sv[k], ICP_OK);
      end
      chk(rot, {sv[3], sv[4], sv[5]});
      chk(ins, {sv[0], sv[1][7:0]});
      chk(mv, sv[2] == 1);
    end
    @(posedge clk);
    mp <= $urandom;
    mr <= 8'($urandom);
    a(1, IDX_LEVEL_TRIG, 2, 0, ICP_OK);
    chk(ins, {sv[0], sv[1][7:0]});
    chk(cap, 1'b0);
    // Machine taken as level and clear of gimbal lock
    a(1, IDX_LEVEL_TRIG, 1, 0, ICP_OK);
    chk(ins, {mp, mr});
    chk(cap, 1'b1);
    a(0, IDX_LEVEL_TRIG, 0, 0, ICP_OK);
    a(0, 16'h2500, 0, 0, ICP_NO_OBJ);
    for (int k = 0; k < 8; k++) a(0, ix(16'h2400, k), 0, 0, ICP_OK);
    @(posedge clk);
    for (int k = 0; k < 8; k++) cal[32 * k +: 32] <= $urandom;
    ld <= 1;
    @(posedge clk);
    ld <= 0;
    for (int k = 0; k < 8; k++) begin
      t = cal[32 * k +: 32];
      if (k == 1) t = t & 32'h0000_00ff;
      a(1, ix(16'h2400, k), ~t, 0, ICP_RO_ERR);
      a(0, ix(16'h2400, k), 0, t, ICP_OK);
    end
    // Reset in mid-run: every object returns to its reset value
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    chk(rot, 96'h0);
    chk(ins, 40'h0);
    chk(mv, 1'b0);
    chk(cap, 1'b0);
    a(0, IDX_INIT_ROLL, 0, 0, ICP_OK);
    a(0, IDX_GYRO_Z, 0, 0, ICP_OK);
    complete_run;
  end
endmodule // testbench
bind icp_bank icp_chk u_chk (
  .REF_CLK(REF_CLK),
  .RST_N(RST_N),
  .ACC_VALID(ACC_VALID),
  .ACC_WRITE(ACC_WRITE),
  .ACC_INDEX(ACC_INDEX),
  .ACC_WDATA(ACC_WDATA),
  .ACC_DONE(ACC_DONE),
  .ACC_RDATA(ACC_RDATA),
  .ACC_RESP(ACC_RESP),
  .MEAS_PITCH(MEAS_PITCH),
  .MEAS_ROLL(MEAS_ROLL),
  .FRAME_ROT(FRAME_ROT),
  .MOUNT_VERTICAL(MOUNT_VERTICAL),
  .INSTALL_ANGLES(INSTALL_ANGLES),
  .LEVEL_CAPTURED(LEVEL_CAPTURED)
);
`default_nettype wire
